// ==== crs_pkg.sv ====
// What this block does
// [RULE1] Bits 6:4 of the range byte pick the current-sense quick-trip full scale.
// [RULE2] Current field resets to 000b (1.250 V); higher codes shrink it to 0.3141 V.
// [RULE3] Bits 2:0 of the range byte pick the power-sense full-scale comparison voltage.
// [RULE4] The power setting feeds both the power quick-trip and the power loop monitor.
// [RULE5] Power field resets to 000b (2.500 V); code 100b gives 1.0030 V.
// [RULE6] Byte is nonvolatile, factory zero, password gated; bits 7 and 3 read zero.
package crs_pkg;

  localparam int CRS_ADDR_W = 8;
  localparam int CRS_DATA_W = 8;
  localparam int CRS_CODE_W = 3;
  localparam int CRS_FS_W = 16;

  localparam logic [CRS_ADDR_W-1:0] CRS_RANGE_ADDR = 8'hb9;
  localparam logic [CRS_DATA_W-1:0] CRS_RANGE_RESET = 8'h00;
  localparam logic [CRS_DATA_W-1:0] CRS_RANGE_MASK = 8'h77;
  localparam int CRS_CUR_LSB = 4;
  localparam int CRS_PWR_LSB = 0;

  // Full scales in units of 100 uV, entry i at bits [16*i +: 16]
  localparam logic [8*CRS_FS_W-1:0] CRS_CUR_TABLE = {
    16'h0c45, 16'h0e04, 16'h1057, 16'h1397,
    16'h1877, 16'h2095, 16'h2715, 16'h30d4};
  localparam logic [CRS_FS_W-1:0] CRS_PWR_FS_0 = 16'h61a8;
  localparam logic [CRS_FS_W-1:0] CRS_PWR_FS_1 = 16'h4e2a;
  localparam logic [CRS_FS_W-1:0] CRS_PWR_FS_2 = 16'h412b;
  localparam logic [CRS_FS_W-1:0] CRS_PWR_FS_3 = 16'h30ed;
  localparam logic [CRS_FS_W-1:0] CRS_PWR_FS_4 = 16'h272e;
  localparam logic [CRS_FS_W-1:0] CRS_CUR_FS_MAX = 16'h30d4;
  localparam logic [CRS_FS_W-1:0] CRS_CUR_FS_MIN = 16'h0c45;

  function automatic logic [CRS_CODE_W-1:0] crs_field(
    input logic [CRS_DATA_W-1:0] value,
    input int lsb
  );
    crs_field = value[lsb +: CRS_CODE_W];
  endfunction

endpackage

// ==== crs_scale_lookup.sv ====
`timescale 1ns/1ps
`default_nettype none
module crs_scale_lookup #(
  parameter logic [8*crs_pkg::CRS_FS_W-1:0] TABLE = '0
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [crs_pkg::CRS_CODE_W-1:0] code_in,
  output logic [crs_pkg::CRS_FS_W-1:0] full_scale_out
);
  import crs_pkg::*;

  // Registered so the analog side never sees a decode glitch
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      full_scale_out <= TABLE[0 +: CRS_FS_W];
    end else begin
      full_scale_out <= TABLE[CRS_FS_W*code_in +: CRS_FS_W];
    end
  end
endmodule
`default_nettype wire

// ==== crs_nv_byte.sv ====
`timescale 1ns/1ps
`default_nettype none
module crs_nv_byte (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic write_in,
  input wire logic [crs_pkg::CRS_DATA_W-1:0] data_in,
  output logic [crs_pkg::CRS_DATA_W-1:0] data_out
);
  import crs_pkg::*;

  // Reset stands in for the factory image; reserved bits never store
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      data_out <= CRS_RANGE_RESET; // [RULE6]
    end else if (write_in) begin
      data_out <= data_in & CRS_RANGE_MASK; // [RULE6]
    end
  end
endmodule
`default_nettype wire

// ==== crs_comparator_range_select.sv ====
`timescale 1ns/1ps
`default_nettype none
module crs_comparator_range_select #(
  parameter logic [crs_pkg::CRS_FS_W-1:0] PWR_FS_5 = 16'h0000,
  parameter logic [crs_pkg::CRS_FS_W-1:0] PWR_FS_6 = 16'h0000,
  parameter logic [crs_pkg::CRS_FS_W-1:0] PWR_FS_7 = 16'h0000
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [crs_pkg::CRS_ADDR_W-1:0] addr_in,
  input wire logic [crs_pkg::CRS_DATA_W-1:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic upper_level_password_in,
  output logic [crs_pkg::CRS_DATA_W-1:0] rd_data_out,
  output logic access_denied_out,
  output logic [crs_pkg::CRS_CODE_W-1:0] current_range_code_out,
  output logic [crs_pkg::CRS_CODE_W-1:0] power_loop_scale_out,
  output logic [crs_pkg::CRS_FS_W-1:0] current_full_scale_out,
  output logic [crs_pkg::CRS_FS_W-1:0] power_trip_full_scale_out,
  output logic [crs_pkg::CRS_FS_W-1:0] power_loop_full_scale_out
);
  import crs_pkg::*;

  localparam logic [8*CRS_FS_W-1:0] PWR_TABLE = {
    PWR_FS_7, PWR_FS_6, PWR_FS_5, CRS_PWR_FS_4,
    CRS_PWR_FS_3, CRS_PWR_FS_2, CRS_PWR_FS_1, CRS_PWR_FS_0};

  logic hit;
  logic write_ok;
  logic read_ok;
  logic denied;
  logic [CRS_DATA_W-1:0] range_byte;
  logic [CRS_DATA_W-1:0] next_rd_data;
  logic [CRS_FS_W-1:0] power_fs;

  always_comb begin
    hit = 1'b0;
    if (addr_in == CRS_RANGE_ADDR) begin
      hit = 1'b1;
    end
  end

  // Unmapped or locked accesses are ignored, reads answer zero
  assign write_ok = wr_in && hit && upper_level_password_in; // [RULE6]
  assign read_ok = rd_in && hit && upper_level_password_in; // [RULE6]
  assign denied = (wr_in || rd_in) && hit && !upper_level_password_in;

  crs_nv_byte u_store (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .write_in(write_ok),
    .data_in(wr_data_in),
    .data_out(range_byte)
  );

  always_comb begin
    next_rd_data = 8'h00;
    if (read_ok) begin
      next_rd_data = range_byte & CRS_RANGE_MASK; // [RULE6]
    end
  end

  // Read data stand for exactly the cycle after the strobe
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_data_out <= 8'h00;
    end else begin
      rd_data_out <= next_rd_data;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      access_denied_out <= 1'b0;
    end else begin
      access_denied_out <= denied;
    end
  end

  assign current_range_code_out = crs_field(range_byte, CRS_CUR_LSB); // [RULE1]
  assign power_loop_scale_out = crs_field(range_byte, CRS_PWR_LSB); // [RULE3]

  crs_scale_lookup #(
    .TABLE(CRS_CUR_TABLE)
  ) u_cur_lookup (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .code_in(current_range_code_out), // [RULE2]
    .full_scale_out(current_full_scale_out)
  );

  crs_scale_lookup #(
    .TABLE(PWR_TABLE)
  ) u_pwr_lookup (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .code_in(power_loop_scale_out), // [RULE5]
    .full_scale_out(power_fs)
  );

  // One decode feeds both users so they can never disagree
  assign power_trip_full_scale_out = power_fs; // [RULE4]
  assign power_loop_full_scale_out = power_fs; // [RULE4]

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);

  property p_cur_field;
    write_ok |=> current_range_code_out == $past(wr_data_in[6:4]);
  endproperty
  a_cur_field: assert property (p_cur_field) // [RULE1]
    else $error("current range code not taken from bits 6:4");

  property p_cur_min;
    (write_ok && wr_data_in[6:4] == 3'h7) |=> ##1 current_full_scale_out == CRS_CUR_FS_MIN;
  endproperty
  a_cur_min: assert property (p_cur_min) // [RULE2]
    else $error("code 7 did not give the smallest current full scale");

  property p_cur_default;
    (current_range_code_out == 3'h0) |=> current_full_scale_out == CRS_CUR_FS_MAX;
  endproperty
  a_cur_default: assert property (p_cur_default) // [RULE2]
    else $error("code 0 did not give the largest current full scale");

  property p_pwr_field;
    write_ok |=> power_loop_scale_out == $past(wr_data_in[2:0]);
  endproperty
  a_pwr_field: assert property (p_pwr_field) // [RULE3]
    else $error("power scale not taken from bits 2:0");

  property p_pwr_shared;
    power_trip_full_scale_out == power_loop_full_scale_out;
  endproperty
  a_pwr_shared: assert property (p_pwr_shared) // [RULE4]
    else $error("power trip and loop full scales differ");

  property p_pwr_code4;
    (power_loop_scale_out == 3'h4) |=> power_loop_full_scale_out == CRS_PWR_FS_4;
  endproperty
  a_pwr_code4: assert property (p_pwr_code4) // [RULE5]
    else $error("power code 4 full scale wrong");

  property p_pwr_default;
    (power_loop_scale_out == 3'h0) |=> power_trip_full_scale_out == CRS_PWR_FS_0;
  endproperty
  a_pwr_default: assert property (p_pwr_default) // [RULE5]
    else $error("power code 0 full scale wrong");

  property p_locked_write;
    (wr_in && !upper_level_password_in) |=> $stable(range_byte);
  endproperty
  a_locked_write: assert property (p_locked_write) // [RULE6]
    else $error("write changed the byte without password");

  property p_read_data;
    read_ok |=> rd_data_out == ($past(range_byte) & CRS_RANGE_MASK) ##1
      (rd_data_out == 8'h00 || $past(read_ok));
  endproperty
  a_read_data: assert property (p_read_data) // [RULE6]
    else $error("read data wrong or held too long");

  property p_reserved_zero;
    rd_data_out[7] == 1'b0 && rd_data_out[3] == 1'b0 && range_byte[7] == 1'b0 &&
      range_byte[3] == 1'b0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) // [RULE6]
    else $error("reserved bit read as one");

  property p_denied_read;
    (rd_in && !upper_level_password_in) |=> rd_data_out == 8'h00;
  endproperty
  a_denied_read: assert property (p_denied_read) // [RULE6]
    else $error("locked read returned data");

  property p_write_lands;
    (wr_in && addr_in == CRS_RANGE_ADDR && upper_level_password_in) |=>
      range_byte == ($past(wr_data_in) & CRS_RANGE_MASK);
  endproperty
  a_write_lands: assert property (p_write_lands) // [RULE6]
    else $error("accepted write did not land in the byte");

  property p_byte_holds;
    !write_ok |=> $stable(range_byte);
  endproperty
  a_byte_holds: assert property (p_byte_holds) // [RULE6]
    else $error("byte changed with no accepted write");

  property p_codes_hold;
    !write_ok |=> $stable(current_range_code_out) && $stable(power_loop_scale_out);
  endproperty
  a_codes_hold: assert property (p_codes_hold) // [RULE1]
    else $error("range codes moved with no accepted write");

  property p_unmapped_write;
    (wr_in && addr_in != CRS_RANGE_ADDR) |=> $stable(range_byte);
  endproperty
  a_unmapped_write: assert property (p_unmapped_write) // [RULE6]
    else $error("write to another address changed the byte");

  property p_unmapped_read;
    (rd_in && addr_in != CRS_RANGE_ADDR) |=> rd_data_out == 8'h00 && !access_denied_out;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) // [RULE6]
    else $error("read of another address answered");

  // Built from the pins, so a broken decode above cannot hide itself
  property p_denied_pulse;
    ((wr_in || rd_in) && addr_in == CRS_RANGE_ADDR && !upper_level_password_in) |=>
      access_denied_out;
  endproperty
  a_denied_pulse: assert property (p_denied_pulse) // [RULE6]
    else $error("locked access gave no denied pulse");

  property p_denied_quiet;
    !((wr_in || rd_in) && addr_in == CRS_RANGE_ADDR && !upper_level_password_in) |=>
      !access_denied_out;
  endproperty
  a_denied_quiet: assert property (p_denied_quiet) // [RULE6]
    else $error("denied pulse without a locked access");

  property p_read_clears;
    !rd_in |=> rd_data_out == 8'h00;
  endproperty
  a_read_clears: assert property (p_read_clears) // [RULE6]
    else $error("read data stood beyond one cycle");

  property p_read_after_write;
    (write_ok ##1 read_ok) |=> rd_data_out == ($past(wr_data_in, 2) & CRS_RANGE_MASK);
  endproperty
  a_read_after_write: assert property (p_read_after_write) // [RULE6]
    else $error("read straight after a write missed the new value");

  property p_reset_values;
    $fell(rst_in) |-> range_byte == CRS_RANGE_RESET && rd_data_out == 8'h00 &&
      current_full_scale_out == CRS_CUR_FS_MAX && power_trip_full_scale_out == CRS_PWR_FS_0;
  endproperty
  a_reset_values: assert property (p_reset_values) // [RULE2]
    else $error("outputs not at their reset values after reset");

  property p_cur_shrinks;
    (current_range_code_out > $past(current_range_code_out)) |=>
      current_full_scale_out < $past(current_full_scale_out);
  endproperty
  a_cur_shrinks: assert property (p_cur_shrinks) // [RULE2]
    else $error("higher current code did not give a smaller full scale");

  // Power codes above 4 are free parameters, so order is only known up to 4
  property p_pwr_shrinks;
    (power_loop_scale_out > $past(power_loop_scale_out) && power_loop_scale_out <= 3'h4) |=>
      power_loop_full_scale_out < $past(power_loop_full_scale_out);
  endproperty
  a_pwr_shrinks: assert property (p_pwr_shrinks) // [RULE5]
    else $error("higher power code did not give a smaller full scale");

  property p_cur_fs_hold;
    $stable(current_range_code_out) |=> $stable(current_full_scale_out);
  endproperty
  a_cur_fs_hold: assert property (p_cur_fs_hold) // [RULE2]
    else $error("current full scale moved with a steady code");

  property p_pwr_fs_hold;
    $stable(power_loop_scale_out) |=> $stable(power_loop_full_scale_out);
  endproperty
  a_pwr_fs_hold: assert property (p_pwr_fs_hold) // [RULE5]
    else $error("power full scale moved with a steady code");

  property p_cur_isolated;
    (write_ok && crs_field(wr_data_in, CRS_CUR_LSB) == current_range_code_out) |=>
      ##1 $stable(current_full_scale_out);
  endproperty
  a_cur_isolated: assert property (p_cur_isolated) // [RULE1]
    else $error("power-only write moved the current full scale");

  property p_pwr_isolated;
    (write_ok && crs_field(wr_data_in, CRS_PWR_LSB) == power_loop_scale_out) |=>
      ##1 $stable(power_trip_full_scale_out);
  endproperty
  a_pwr_isolated: assert property (p_pwr_isolated) // [RULE3]
    else $error("current-only write moved the power full scale");

  // Every table entry is checked, not just the two ends
  for (genvar code = 0; code < 8; code++) begin : g_scale_check
    property p_cur_table;
      @(posedge sys_clk_in) disable iff (rst_in)
        (current_range_code_out == CRS_CODE_W'(code)) |=>
        current_full_scale_out == CRS_CUR_TABLE[CRS_FS_W*code +: CRS_FS_W];
    endproperty
    a_cur_table: assert property (p_cur_table) // [RULE2]
      else $error("current full scale does not match its code");

    property p_pwr_table;
      @(posedge sys_clk_in) disable iff (rst_in)
        (power_loop_scale_out == CRS_CODE_W'(code)) |=>
        power_trip_full_scale_out == PWR_TABLE[CRS_FS_W*code +: CRS_FS_W] &&
        power_loop_full_scale_out == PWR_TABLE[CRS_FS_W*code +: CRS_FS_W];
    endproperty
    a_pwr_table: assert property (p_pwr_table) // [RULE4]
      else $error("power full scales do not match their code");
  end

  c_write_then_read: cover property (write_ok ##1 read_ok);
  c_denied_write: cover property (wr_in && hit && !upper_level_password_in);
  c_cur_min_scale: cover property (current_full_scale_out == CRS_CUR_FS_MIN);
  c_pwr_code4: cover property (power_loop_full_scale_out == CRS_PWR_FS_4);

endmodule
`default_nettype wire

// ==== crs_comparator_range_select_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module crs_comparator_range_select_test;
  import crs_pkg::*;
  // Codes 5..7 of the power field are free; arbitrary distinct values
  localparam logic [15:0] FS5 = 16'h1f40;
  localparam logic [15:0] FS6 = 16'h1b58;
  localparam logic [15:0] FS7 = 16'h1770;
  logic sys_clk_in = 0, rst_in = 1, wr_in = 0, rd_in = 0, pw = 0;
  logic [7:0] addr_in = 8'h00, wr_data_in = 8'h00, rd_data, model = 8'h00;
  logic denied;
  logic [2:0] cur_code, pwr_code;
  logic [15:0] cur_fs, trip_fs, loop_fs;
  int err_total = 0, total_checks = 0;
  integer seed = 32'h2d29dfcc;
  logic [15:0] cur_tab [8] = '{16'h30d4, 16'h2715, 16'h2095, 16'h1877,
    16'h1397, 16'h1057, 16'h0e04, 16'h0c45};
  logic [15:0] pwr_tab [8] = '{16'h61a8, 16'h4e2a, 16'h412b, 16'h30ed,
    16'h272e, FS5, FS6, FS7};

  crs_comparator_range_select #(.PWR_FS_5(FS5), .PWR_FS_6(FS6), .PWR_FS_7(FS7))
    crs_comparator_range_select_i (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in),
    .upper_level_password_in(pw), .rd_data_out(rd_data), .access_denied_out(denied),
    .current_range_code_out(cur_code), .power_loop_scale_out(pwr_code),
    .current_full_scale_out(cur_fs), .power_trip_full_scale_out(trip_fs),
    .power_loop_full_scale_out(loop_fs));

  initial begin
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end

  function automatic logic [15:0] exp_cur(input logic [2:0] c);
    return cur_tab[c];
  endfunction

  function automatic logic [15:0] exp_pwr(input logic [2:0] c);
    return pwr_tab[c];
  endfunction

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // One strobe, then every output compared against the bench model
  task automatic op(input logic w, input logic [7:0] a, input logic [7:0] d, input logic p);
    logic hit;
    hit = (a == 8'hb9) && p;
    @(posedge sys_clk_in);
    wr_in <= w;
    rd_in <= !w;
    addr_in <= a;
    wr_data_in <= d;
    pw <= p;
    @(posedge sys_clk_in);
    wr_in <= 0;
    rd_in <= 0;
    #1;
    if (w && hit) model = d & 8'h77;
    chk("denied", {15'h0, denied}, {15'h0, a == 8'hb9 && !p});
    if (!w) chk("read", {8'h0, rd_data}, hit ? {8'h0, model} : 16'h0);
    chk("cur code", {13'h0, cur_code}, {13'h0, model[6:4]});
    chk("pwr code", {13'h0, pwr_code}, {13'h0, model[2:0]});
    @(posedge sys_clk_in);
    #1;
    chk("cur fs", cur_fs, exp_cur(model[6:4]));
    chk("trip fs", trip_fs, exp_pwr(model[2:0]));
    chk("loop fs", loop_fs, exp_pwr(model[2:0]));
    chk("read idle", {8'h0, rd_data}, 16'h0);
  endtask

  initial begin
    logic [7:0] a;
    repeat (3) @(posedge sys_clk_in);
    rst_in <= 0;
    op(0, 8'hb9, 8'h00, 1);
    $display("test reset done");
    // Reserved bits set on purpose: they must never come back
    for (int i = 0; i < 8; i++) begin
      op(1, 8'hb9, {1'b1, i[2:0], 1'b1, i[2:0]}, 1);
      op(0, 8'hb9, 8'h00, 1);
    end
    $display("test codes done");
    repeat (80) begin
      a = ($random(seed) & 3) ? 8'hb9 : 8'($random(seed));
      op(1'($random(seed)), a, 8'($random(seed)), ($random(seed) & 7) != 0);
    end
    $display("test random done");
    @(posedge sys_clk_in);
    wr_in <= 1;
    addr_in <= 8'hb9;
    wr_data_in <= 8'h5a;
    pw <= 1;
    @(posedge sys_clk_in);
    wr_in <= 0;
    rd_in <= 1;
    @(posedge sys_clk_in);
    rd_in <= 0;
    #1;
    chk("b2b read", {8'h0, rd_data}, 16'h0052);
    model = 8'h52;
    op(0, 8'hb9, 8'h00, 0);
    $display("test back to back done");
    @(posedge sys_clk_in);
    rst_in <= 1;
    #1;
    chk("rst cur fs", cur_fs, 16'h30d4);
    chk("rst pwr fs", trip_fs, 16'h61a8);
    repeat (2) @(posedge sys_clk_in);
    rst_in <= 0;
    model = 8'h00;
    op(0, 8'hb9, 8'h00, 1);
    $display("test mid reset done");
    finish_test;
  end

  // Whole run is a few hundred cycles; far beyond that means a hang
  initial begin
    repeat (20000) @(posedge sys_clk_in);
    err_total++;
    finish_test;
  end
endmodule
`default_nettype wire
